// [eipu_pkg.sv]
// eipu_pkg: constants and types for the external pin interrupt unit
// assumes a 32-bit axi4-lite register bus with byte addresses below 0x20
package eipu_pkg;

	// bus, pin and request shape
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned REG_W = 8;
	localparam int unsigned PIN_COUNT = 16;
	localparam int unsigned GROUP_PINS = 8;
	localparam int unsigned REQ_COUNT = 4;

	// register byte offsets
	localparam logic [4:0] OFF_SENSE = 5'h00;
	localparam logic [4:0] OFF_EXT_EN = 5'h04;
	localparam logic [4:0] OFF_EXT_PEND = 5'h08;
	localparam logic [4:0] OFF_GRP_EN = 5'h0C;
	localparam logic [4:0] OFF_GRP_PEND = 5'h10;
	localparam logic [4:0] OFF_UP_MASK = 5'h14;
	localparam logic [4:0] OFF_LO_MASK = 5'h18;
	localparam logic [4:0] OFF_PIN_LEVEL = 5'h1C;

	// field positions
	localparam int unsigned SENSE_ZERO_LSB = 0;
	localparam int unsigned SENSE_ONE_LSB = 2;
	localparam int unsigned BIT_ZERO = 0;
	localparam int unsigned BIT_ONE = 1;

	// request line order toward the vector logic
	localparam int unsigned REQ_EXT_ZERO = 0;
	localparam int unsigned REQ_EXT_ONE = 1;
	localparam int unsigned REQ_GRP_ZERO = 2;
	localparam int unsigned REQ_GRP_ONE = 3;

	// values after reset
	localparam logic [3:0] RST_SENSE = 4'h0;
	localparam logic [1:0] RST_FLAGS2 = 2'h0;
	localparam logic [7:0] RST_MASK = 8'h00;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// sense selector codes
	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_ANY = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} eipu_sense_e;

endpackage : eipu_pkg

// [eipu_edge_det.sv]
// eipu_edge_det: sense logic for one dedicated external interrupt pin
// assumes the pin is synchronous to clk; io_clk_run marks a running i/o clock
`timescale 1ns/1ps
module eipu_edge_det (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	input eipu_pkg::eipu_sense_e sense,
	input wire logic io_clk_run,
	output logic level_low,
	output logic trig
);
	logic sample_r;
	logic prev_r;
	logic rise;
	logic fall;

	// sample the pin, then keep the previous sample for edge compare
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			sample_r <= pin;
			prev_r <= sample_r;
		end
	end

	assign rise = sample_r & ~prev_r;
	assign fall = ~sample_r & prev_r;
	assign level_low = ~sample_r;

	// decode the selector; falling and rising edges need the running i/o clock, any-change sense does not
	always_comb begin
		unique case (sense)
			eipu_pkg::SENSE_LOW: trig = 1'b0;
			eipu_pkg::SENSE_ANY: trig = rise | fall;
			eipu_pkg::SENSE_FALL: trig = fall & io_clk_run;
			eipu_pkg::SENSE_RISE: trig = rise & io_clk_run;
		endcase
	end

	// an edge is only flagged outside low-level sense
	a_edge_not_low: assert property (@(posedge clk) disable iff (!rst_b)
		sense == eipu_pkg::SENSE_LOW |-> !trig)
		else $error("edge trigger in low-level sense");

endmodule : eipu_edge_det

// [eipu_top.sv]
// eipu_top: external pin interrupt unit with an axi4-lite register slave
// assumes pins synchronous to CLK, vector entry pulses from the core
`timescale 1ns/1ps
module eipu_top #(
	parameter int unsigned PIN_GROUP_W = 8
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [4:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [4:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic EXT_IRQ_PIN_ZERO,
	input wire logic EXT_IRQ_PIN_ONE,
	input wire logic [15:0] PIN_CHANGE_INPUTS,
	input wire logic GLOBAL_INT_EN,
	input wire logic IO_CLK_RUN,
	input wire logic [3:0] VECTOR_ENTRY,
	output logic [3:0] IRQ_REQ,
	output logic WAKE_REQ
);
	// the mask registers are one byte wide
	initial begin
		if (PIN_GROUP_W == 0 || PIN_GROUP_W > eipu_pkg::GROUP_PINS)
			$error("PIN_GROUP_W must be 1 to 8");
	end

	logic [3:0] sense_r;
	logic [1:0] ext_en_r;
	logic [1:0] ext_pend_r;
	logic [1:0] grp_en_r;
	logic [1:0] grp_pend_r;
	logic [7:0] up_mask_r;
	logic [7:0] lo_mask_r;
	logic [15:0] pc_prev_r;
	logic [3:0] irq_r;
	logic wake_r;
	logic awready_r;
	logic wready_r;
	logic aw_held_r;
	logic w_held_r;
	logic [4:0] waddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic commit;
	logic wr_ok;
	logic [1:0] ext_low;
	logic [1:0] ext_trig;
	logic [1:0] ext_low_mode;
	logic [15:0] pc_change;
	logic [1:0] grp_hit;
	logic [1:0] ext_clr;
	logic [1:0] grp_clr;
	logic [1:0] ext_pend_nxt;
	logic [1:0] grp_pend_nxt;
	logic [3:0] irq_nxt;
	logic [7:0] rd_byte;
	logic rd_hit;
	eipu_pkg::eipu_sense_e sense_zero;
	eipu_pkg::eipu_sense_e sense_one;

	assign sense_zero = eipu_pkg::eipu_sense_e'(
		sense_r[eipu_pkg::SENSE_ZERO_LSB +: 2]);
	assign sense_one = eipu_pkg::eipu_sense_e'(
		sense_r[eipu_pkg::SENSE_ONE_LSB +: 2]);
	assign ext_low_mode[0] = sense_zero == eipu_pkg::SENSE_LOW;
	assign ext_low_mode[1] = sense_one == eipu_pkg::SENSE_LOW;

	// sense logic for the two dedicated pins; the pin is read whatever
	// the port direction, so driving it as an output triggers too
	eipu_edge_det u_ext_zero (
		.clk(CLK),
		.rst_b(RST_B),
		.pin(EXT_IRQ_PIN_ZERO),
		.sense(sense_zero),
		.io_clk_run(IO_CLK_RUN),
		.level_low(ext_low[0]),
		.trig(ext_trig[0])
	);
	eipu_edge_det u_ext_one (
		.clk(CLK),
		.rst_b(RST_B),
		.pin(EXT_IRQ_PIN_ONE),
		.sense(sense_one),
		.io_clk_run(IO_CLK_RUN),
		.level_low(ext_low[1]),
		.trig(ext_trig[1])
	);

	// pin-change compare; runs without the i/o clock
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			pc_prev_r <= 16'h0000;
		else
			pc_prev_r <= PIN_CHANGE_INPUTS;
	end

	// only masked pins of each group contribute
	always_comb begin
		pc_change = 16'h0000;
		for (int i = 0; i < PIN_GROUP_W; i++) begin
			pc_change[i] = (PIN_CHANGE_INPUTS[i] ^ pc_prev_r[i])
				& lo_mask_r[i];
			pc_change[i + 8] = (PIN_CHANGE_INPUTS[i + 8] ^ pc_prev_r[i + 8])
				& up_mask_r[i];
		end
	end
	assign grp_hit[0] = |pc_change[7:0];
	assign grp_hit[1] = |pc_change[15:8];

	// write channel: address and data are taken in either order
	assign commit = aw_held_r & w_held_r & ~bvalid_r;
	assign wr_ok = commit & wlane_r;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b0;
			waddr_r <= 5'h00;
		end else if (S_AXI_AWVALID && awready_r) begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b1;
			waddr_r <= S_AXI_AWADDR;
		end else if (commit) begin
			aw_held_r <= 1'b0;
		end else if (!aw_held_r && !bvalid_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wready_r <= 1'b0;
			w_held_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else if (S_AXI_WVALID && wready_r) begin
			wready_r <= 1'b0;
			w_held_r <= 1'b1;
			wbyte_r <= S_AXI_WDATA[7:0];
			wlane_r <= S_AXI_WSTRB[0];
		end else if (commit) begin
			w_held_r <= 1'b0;
		end else if (!w_held_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	// write response, error for an unmapped or read-only address
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bvalid_r <= 1'b0;
			bresp_r <= eipu_pkg::RESP_OKAY;
		end else if (commit) begin
			bvalid_r <= 1'b1;
			bresp_r <= (waddr_r[4:2] == eipu_pkg::OFF_PIN_LEVEL[4:2]
				|| waddr_r[1:0] != 2'h0) ? eipu_pkg::RESP_SLVERR
				: eipu_pkg::RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// control registers written by software
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sense_r <= eipu_pkg::RST_SENSE;
			ext_en_r <= eipu_pkg::RST_FLAGS2;
			grp_en_r <= eipu_pkg::RST_FLAGS2;
			up_mask_r <= eipu_pkg::RST_MASK;
			lo_mask_r <= eipu_pkg::RST_MASK;
		end else if (wr_ok) begin
			unique case (waddr_r)
				eipu_pkg::OFF_SENSE: sense_r <= wbyte_r[3:0];
				eipu_pkg::OFF_EXT_EN: ext_en_r <= wbyte_r[1:0];
				eipu_pkg::OFF_GRP_EN: grp_en_r <= wbyte_r[1:0];
				eipu_pkg::OFF_UP_MASK: up_mask_r <= wbyte_r;
				eipu_pkg::OFF_LO_MASK: lo_mask_r <= wbyte_r;
				default: ;
			endcase
		end
	end

	// clears: vector entry or a written one; a new event wins
	assign ext_clr = VECTOR_ENTRY[1:0] | ({2{wr_ok
		&& waddr_r == eipu_pkg::OFF_EXT_PEND}} & wbyte_r[1:0]);
	assign grp_clr = VECTOR_ENTRY[3:2] | ({2{wr_ok
		&& waddr_r == eipu_pkg::OFF_GRP_PEND}} & wbyte_r[1:0]);
	assign ext_pend_nxt = ~ext_low_mode
		& (ext_trig | (ext_pend_r & ~ext_clr));
	assign grp_pend_nxt = grp_hit | (grp_pend_r & ~grp_clr);

	// pending flags
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ext_pend_r <= eipu_pkg::RST_FLAGS2;
			grp_pend_r <= eipu_pkg::RST_FLAGS2;
		end else begin
			ext_pend_r <= ext_pend_nxt;
			grp_pend_r <= grp_pend_nxt;
		end
	end

	// four requests, each gated by its enable and the global flag
	always_comb begin
		irq_nxt[eipu_pkg::REQ_EXT_ZERO] = GLOBAL_INT_EN & ext_en_r[0]
			& (ext_low_mode[0] ? ext_low[0] : ext_pend_r[0]);
		irq_nxt[eipu_pkg::REQ_EXT_ONE] = GLOBAL_INT_EN & ext_en_r[1]
			& (ext_low_mode[1] ? ext_low[1] : ext_pend_r[1]);
		irq_nxt[eipu_pkg::REQ_GRP_ZERO] = GLOBAL_INT_EN & grp_en_r[0]
			& grp_pend_r[0];
		irq_nxt[eipu_pkg::REQ_GRP_ONE] = GLOBAL_INT_EN & grp_en_r[1]
			& grp_pend_r[1];
	end

	// request and wake outputs; a low level that ends early wakes
	// the part but leaves no flag behind
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_r <= 4'h0;
			wake_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
			wake_r <= |(ext_en_r & ext_low_mode & ext_low)
				| |(grp_en_r & grp_pend_r);
		end
	end

	// read mux; unused bits return zero
	always_comb begin
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR)
			eipu_pkg::OFF_SENSE: rd_byte = {4'h0, sense_r};
			eipu_pkg::OFF_EXT_EN: rd_byte = {6'h00, ext_en_r};
			eipu_pkg::OFF_EXT_PEND: rd_byte = {6'h00, ext_pend_r};
			eipu_pkg::OFF_GRP_EN: rd_byte = {6'h00, grp_en_r};
			eipu_pkg::OFF_GRP_PEND: rd_byte = {6'h00, grp_pend_r};
			eipu_pkg::OFF_UP_MASK: rd_byte = up_mask_r;
			eipu_pkg::OFF_LO_MASK: rd_byte = lo_mask_r;
			eipu_pkg::OFF_PIN_LEVEL: rd_byte = {4'h0, ext_pend_nxt,
				~ext_low};
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read channel: one read at a time, answer one cycle after taking
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= eipu_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_byte};
			rresp_r <= rd_hit ? eipu_pkg::RESP_OKAY : eipu_pkg::RESP_SLVERR;
		end else if (rvalid_r && S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
	assign IRQ_REQ = irq_r;
	assign WAKE_REQ = wake_r;

	// checks on the request, flag and read data behaviour
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_upper_change_flag: assert property (grp_hit[1] |=> grp_pend_r[1])
		else $error("upper group change did not set flag");
	a_lower_change_flag: assert property (grp_hit[0] |=> grp_pend_r[0])
		else $error("lower group change did not set flag");
	a_masked_pin_quiet: assert property (
		up_mask_r == 8'h00 && !grp_pend_r[1] |=> !grp_pend_r[1])
		else $error("flag set with upper mask clear");
	a_low_level_req: assert property (
		GLOBAL_INT_EN && ext_en_r[0] && ext_low_mode[0] && ext_low[0]
		|=> IRQ_REQ[eipu_pkg::REQ_EXT_ZERO])
		else $error("low level did not request");
	a_low_pend_zero: assert property (
		ext_low_mode == 2'h3 |=> ext_pend_r == 2'h0)
		else $error("pending flag set in low-level sense");
	a_edge_sets_flag: assert property (
		ext_trig[1] && !ext_low_mode[1] |=> ext_pend_r[1])
		else $error("edge did not set pending flag");
	a_edge_needs_clk: assert property (
		!IO_CLK_RUN && sense_zero == eipu_pkg::SENSE_FALL
		|-> !ext_trig[0])
		else $error("falling edge seen with i/o clock stopped");
	a_global_gate: assert property (
		!GLOBAL_INT_EN |=> IRQ_REQ == 4'h0)
		else $error("request without global flag");
	a_entry_clears: assert property (
		VECTOR_ENTRY[0] && !ext_trig[0] |=> !ext_pend_r[0])
		else $error("vector entry did not clear flag");
	a_held_flag_req: assert property (
		grp_pend_r[1] && !grp_clr[1] ##1 GLOBAL_INT_EN && grp_en_r[1]
		|=> IRQ_REQ[eipu_pkg::REQ_GRP_ONE])
		else $error("kept flag not requested");
	a_reserved_zero: assert property (
		S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("unused read bits not zero");

	c_low_level_req: cover property (IRQ_REQ[eipu_pkg::REQ_EXT_ZERO]
		&& ext_low_mode[0]);
	c_group_one_req: cover property (IRQ_REQ[eipu_pkg::REQ_GRP_ONE]);
	c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
	c_read_error: cover property (S_AXI_RVALID
		&& S_AXI_RRESP == eipu_pkg::RESP_SLVERR);

endmodule : eipu_top

// [eipu_pin_model.sv]
// eipu_pin_model: board-side drivers of the two dedicated and sixteen
// pin-change interrupt pins; assumes the bench commands the wanted levels
`timescale 1ns/1ps
module eipu_pin_model (
	input wire logic clk,
	input wire logic [17:0] want,
	output logic [17:0] pins
);
	// each level is driven just after clk rises and held until changed,
	// so a low level stays through any instruction or start-up time
	always_ff @(posedge clk) begin
		pins <= want;
	end
endmodule : eipu_pin_model

// [eipu_bench.sv]
// eipu_bench: self-checking bench for the external pin interrupt unit
// assumes eipu_top, eipu_pkg and eipu_pin_model are compiled first
`timescale 1ns/1ps
module eipu_bench;
	logic clk, rst_b, awv, wv, bry, arv, rry, gie, ioc;
	logic awr, wrd, bv, arr, rv, wake;
	logic [4:0] awa, ara;
	logic [31:0] wd, rdata, seed;
	logic [1:0] bresp, rresp;
	logic [3:0] vent, irq, ws;
	logic [17:0] want, pins;
	logic [33:0] rd_q[$];
	logic [1:0] b_q[$];
	int mismatches, checks_done, p, m, k, g, b;
	logic f, hit;
	logic [7:0] msk;

	eipu_pin_model PINS (.clk(clk), .want(want), .pins(pins));
	eipu_top DUT (.CLK(clk), .RST_B(rst_b),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.EXT_IRQ_PIN_ZERO(pins[0]), .EXT_IRQ_PIN_ONE(pins[1]),
		.PIN_CHANGE_INPUTS(pins[17:2]), .GLOBAL_INT_EN(gie),
		.IO_CLK_RUN(ioc), .VECTOR_ENTRY(vent), .IRQ_REQ(irq),
		.WAKE_REQ(wake));

	// clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// xorshift source for random masks and pin picks
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [33:0] got, input logic [33:0] exp,
		input string msg);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : chk

	// one axi4-lite write or read; the answer is judged by the monitor
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [7:0] d, input logic [1:0] r = eipu_pkg::RESP_OKAY);
		logic aw_t, w_t, ar_t, done;
		done = 1'b0;
		@(posedge clk);
		if (wr) begin
			b_q.push_back(r);
			awa <= a;
			wd <= {24'h000000, d};
			awv <= 1'b1;
			wv <= 1'b1;
			bry <= 1'b1;
		end else begin
			rd_q.push_back({r, 24'h000000, d});
			ara <= a;
			arv <= 1'b1;
			rry <= 1'b1;
		end
		while (!done) begin
			@(negedge clk);
			aw_t = awv && awr;
			w_t = wv && wrd;
			ar_t = arv && arr;
			done = wr ? (bv && bry) : (rv && rry);
			@(posedge clk);
			if (aw_t) awv <= 1'b0;
			if (w_t) wv <= 1'b0;
			if (ar_t) arv <= 1'b0;
		end
		bry <= 1'b0;
		rry <= 1'b0;
	endtask : bus

	task automatic chk_irq(input int i, input logic e);
		@(negedge clk);
		chk({31'h0, irq[i]}, {31'h0, e}, "request line");
	endtask : chk_irq

	task automatic pulse_vec(input logic [3:0] v);
		@(posedge clk);
		vent <= v;
		@(posedge clk);
		vent <= 4'h0;
		repeat (3) @(posedge clk);
	endtask : pulse_vec

	// compare each bus answer with the oldest note
	always @(negedge clk) begin
		if (bv && bry) begin
			if (b_q.size() == 0) chk(1, 0, "unexpected write answer");
			else chk({30'h0, bresp}, {30'h0, b_q.pop_front()}, "bresp");
		end
		if (rv && rry) begin
			if (rd_q.size() == 0) chk(1, 0, "unexpected read answer");
			else chk({rresp, rdata}, rd_q.pop_front(), "read");
		end
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end

	// main sequence
	initial begin
		{rst_b, awv, wv, bry, arv, rry, gie, ioc} = 8'h01;
		{awa, ara, wd, vent} = '0;
		ws = 4'h1;
		want = '1;
		seed = 32'hFE59;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 7; k++) bus(0, 5'(k * 4), 8'h00);
		$display("test reset values finished");
		bus(1, eipu_pkg::OFF_SENSE, 8'hFF);
		bus(0, eipu_pkg::OFF_SENSE, 8'h0F);
		bus(1, eipu_pkg::OFF_EXT_EN, 8'hFF);
		bus(0, eipu_pkg::OFF_EXT_EN, 8'h03);
		bus(1, eipu_pkg::OFF_GRP_EN, 8'hFF);
		bus(0, eipu_pkg::OFF_GRP_EN, 8'h03);
		bus(1, eipu_pkg::OFF_UP_MASK, 8'hA5);
		bus(0, eipu_pkg::OFF_UP_MASK, 8'hA5);
		bus(1, eipu_pkg::OFF_LO_MASK, 8'h5A);
		bus(0, eipu_pkg::OFF_LO_MASK, 8'h5A);
		ws <= 4'h0;
		bus(1, eipu_pkg::OFF_UP_MASK, 8'h00);
		ws <= 4'h1;
		bus(0, eipu_pkg::OFF_UP_MASK, 8'hA5);
		bus(0, 5'h01, 8'h00, eipu_pkg::RESP_SLVERR);
		bus(1, eipu_pkg::OFF_PIN_LEVEL, 8'h01, eipu_pkg::RESP_SLVERR);
		bus(1, 5'h02, 8'h01, eipu_pkg::RESP_SLVERR);
		bus(0, eipu_pkg::OFF_PIN_LEVEL, 8'h03);
		bus(0, eipu_pkg::OFF_EXT_PEND, 8'h00);
		$display("test register map finished");
		gie <= 1'b1;
		ioc <= 1'b1;
		bus(1, eipu_pkg::OFF_GRP_EN, 8'h00);
		bus(1, eipu_pkg::OFF_EXT_EN, 8'h03);
		for (p = 0; p < 2; p++) begin
			for (m = 0; m < 4; m++) begin
				bus(1, eipu_pkg::OFF_SENSE, 8'(m << (2 * p)));
				bus(1, eipu_pkg::OFF_EXT_PEND, 8'h03);
				want[p] <= 1'b0;
				repeat (4) @(posedge clk);
				f = (m == 1 || m == 2);
				bus(0, eipu_pkg::OFF_EXT_PEND, 8'(f) << p);
				chk_irq(p, m == 0 || f);
				chk({33'h0, wake}, {33'h0, m == 0}, "wake request");
				bus(1, eipu_pkg::OFF_EXT_PEND, 8'(1 << p));
				want[p] <= 1'b1;
				repeat (4) @(posedge clk);
				f = (m == 1 || m == 3);
				bus(0, eipu_pkg::OFF_EXT_PEND, 8'(f) << p);
				chk_irq(p, f);
				chk({33'h0, wake}, 34'h0, "wake after release");
			end
		end
		$display("test sense modes finished");
		bus(1, eipu_pkg::OFF_SENSE, 8'h02);
		ioc <= 1'b0;
		want[0] <= 1'b0;
		repeat (4) @(posedge clk);
		bus(0, eipu_pkg::OFF_EXT_PEND, 8'h00);
		bus(1, eipu_pkg::OFF_SENSE, 8'h01);
		want[0] <= 1'b1;
		repeat (4) @(posedge clk);
		chk_irq(0, 1'b1);
		pulse_vec(4'h1);
		chk_irq(0, 1'b0);
		bus(0, eipu_pkg::OFF_EXT_PEND, 8'h00);
		$display("test clock gating and vector finished");
		bus(1, eipu_pkg::OFF_EXT_EN, 8'h00);
		bus(1, eipu_pkg::OFF_GRP_EN, 8'h03);
		for (k = 0; k < 8; k++) begin
			seed = xs(seed);
			g = int'(seed[8]);
			b = int'(seed[11:9]);
			msk = seed[7:0];
			hit = msk[b];
			if (g == 1) bus(1, eipu_pkg::OFF_UP_MASK, msk);
			else bus(1, eipu_pkg::OFF_LO_MASK, msk);
			bus(1, eipu_pkg::OFF_GRP_PEND, 8'h03);
			want[2 + 8 * g + b] <= ~want[2 + 8 * g + b];
			repeat (3) @(posedge clk);
			bus(0, eipu_pkg::OFF_GRP_PEND, 8'(hit) << g);
			chk_irq(2 + g, hit);
		end
		$display("test pin change groups finished");
		bus(1, eipu_pkg::OFF_LO_MASK, 8'hFF);
		bus(1, eipu_pkg::OFF_GRP_EN, 8'h00);
		bus(1, eipu_pkg::OFF_GRP_PEND, 8'h03);
		want[2] <= ~want[2];
		repeat (3) @(posedge clk);
		chk_irq(2, 1'b0);
		@(posedge clk);
		gie <= 1'b0;
		bus(1, eipu_pkg::OFF_GRP_EN, 8'h01);
		chk_irq(2, 1'b0);
		chk({33'h0, wake}, 34'h1, "wake from held flag");
		@(posedge clk);
		gie <= 1'b1;
		repeat (2) @(posedge clk);
		chk_irq(2, 1'b1);
		pulse_vec(4'h4);
		chk_irq(2, 1'b0);
		$display("test held flag finished");
		conclude();
	end
endmodule : eipu_bench
